//--- pkg/rxgl_pkg.sv
package rxgl_pkg;

  // Second amplifier stage gain codes
  typedef enum logic [1:0] {
    RXGL_AMP_MIN = 2'h0,
    RXGL_AMP_MED = 2'h1,
    RXGL_AMP_MAX = 2'h2,
    RXGL_AMP_MID_HIGH = 2'h3
  } rxgl_amp_t;

  // Hysteresis tracker, one-hot
  typedef enum logic [2:0] {
    RXGL_HOLD = 3'h1,
    RXGL_PEND_UP = 3'h2,
    RXGL_PEND_DN = 3'h4
  } rxgl_hyst_t;

endpackage

//--- pkg/rxgl_regs.svh
`ifndef RXGL_REGS_SVH
`define RXGL_REGS_SVH

// Register offsets on the configuration port
`define RXGL_GAIN_STAGE_CONTROL_OFS 7'h12
`define RXGL_GAIN_THRESHOLD_START_OFS 7'h13

// Reset values
`define RXGL_GAIN_STAGE_CONTROL_RST 8'h75
`define RXGL_GAIN_THRESHOLD_START_RST 8'h38

// gain_stage_control fields
`define RXGL_FLOOR_BIT 7
`define RXGL_CEIL_BIT 6
`define RXGL_SWP_MSB 5
`define RXGL_SWP_LSB 4
`define RXGL_OFF_BIT 3
`define RXGL_HYST_BIT 2
`define RXGL_AVG_MSB 1
`define RXGL_AVG_LSB 0

// gain_threshold_start fields
`define RXGL_DOWN_MSB 7
`define RXGL_DOWN_LSB 5
`define RXGL_INIT_MSB 4
`define RXGL_INIT_LSB 0

// Down-margin base, 4.5 dB in 1.5 dB level units
`define RXGL_DOWN_BASE 7'h03

// Amplifier codes at which the second stage switches
`define RXGL_SWP_CODE0 6'h00
`define RXGL_SWP_CODE1 6'h0a
`define RXGL_SWP_CODE2 6'h13
`define RXGL_SWP_CODE3 6'h20

`endif

//--- rtl/rxgl_core.sv
// Function
// - Floor bit picks second stage lowest gain: 0 minimum, 1 medium.
// - Ceiling bit picks second stage highest gain: 0 medium, 1 maximum.
// - Switch-point code picks amplifier code where second stage switches.
// - Floor 1 with ceiling 0 fixes second stage gain from switch-point code.
// - Loop-off bit holds amplifier gain at the initial gain code.
// - Hysteresis demands two consecutive evaluations before a single step.
// - Magnitude averaged over 2, 4, 8 or 16 samples by code.
// - Gain lowered above reference plus up-margin plus 4.5 to 15 dB down-margin.
// - Initial gain code loaded whenever receive chain switches on.
// - Loop never raises gain above initial gain code.
// - Gain raised below reference plus 0 to 10.5 dB up-margin.
// - Five-bit sense reference is the common threshold base.
`timescale 1ns/1ps
`default_nettype none
`include "rxgl_regs.svh"

module rxgl_core #(
  parameter int MAG_W = 8
) (
  input wire logic clk, // 250 MHz
  input wire logic rst_n, // Sync reset, active low
  input wire logic [6:0] cfg_addr, // Register offset
  input wire logic cfg_wr_en, // Write strobe
  input wire logic cfg_rd_en, // Read strobe
  input wire logic [7:0] cfg_wdata, // Write data
  output logic [7:0] cfg_rdata, // Read data, held
  input wire logic rx_on, // Receive chain enabled
  input wire logic sample_valid, // Filter output strobe
  input wire logic [MAG_W-1:0] sample_mag, // Magnitude, 1.5 dB units
  input wire logic [4:0] sense_level, // Sense reference
  input wire logic [2:0] up_margin, // Up-margin code
  output logic [4:0] vga_gain, // Amplifier gain code
  output rxgl_pkg::rxgl_amp_t second_amp_stage, // Second stage gain
  output logic [MAG_W-1:0] avg_mag, // Averaged magnitude
  output logic avg_valid // One-cycle pulse per average
);
  import rxgl_pkg::*;

  // ************************************************
  // Registers
  // ************************************************
  logic [7:0] ctrl_ff, nxt_ctrl;
  logic [7:0] thr_ff, nxt_thr;
  logic [7:0] rdata_ff, nxt_rdata;

  always_comb begin
    nxt_ctrl = ctrl_ff;
    nxt_thr = thr_ff;
    nxt_rdata = rdata_ff;
    if (cfg_wr_en && cfg_addr == `RXGL_GAIN_STAGE_CONTROL_OFS) begin
      nxt_ctrl = cfg_wdata;
    end
    if (cfg_wr_en && cfg_addr == `RXGL_GAIN_THRESHOLD_START_OFS) begin
      nxt_thr = cfg_wdata;
    end
    if (cfg_rd_en) begin
      unique case (cfg_addr)
        `RXGL_GAIN_STAGE_CONTROL_OFS: nxt_rdata = ctrl_ff;
        `RXGL_GAIN_THRESHOLD_START_OFS: nxt_rdata = thr_ff;
        default: nxt_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctrl_ff <= `RXGL_GAIN_STAGE_CONTROL_RST;
      thr_ff <= `RXGL_GAIN_THRESHOLD_START_RST;
      rdata_ff <= 8'h00;
    end else begin
      ctrl_ff <= nxt_ctrl;
      thr_ff <= nxt_thr;
      rdata_ff <= nxt_rdata;
    end
  end

  assign cfg_rdata = rdata_ff;

  logic floor_sel, ceil_sel, gain_loop_off, gain_step_hyst;
  logic [1:0] switch_point, magnitude_avg_len;
  logic [2:0] down_code;
  logic [4:0] init_gain;

  assign floor_sel = ctrl_ff[`RXGL_FLOOR_BIT];
  assign ceil_sel = ctrl_ff[`RXGL_CEIL_BIT];
  assign switch_point = ctrl_ff[`RXGL_SWP_MSB:`RXGL_SWP_LSB];
  assign gain_loop_off = ctrl_ff[`RXGL_OFF_BIT];
  assign gain_step_hyst = ctrl_ff[`RXGL_HYST_BIT];
  assign magnitude_avg_len = ctrl_ff[`RXGL_AVG_MSB:`RXGL_AVG_LSB];
  assign down_code = thr_ff[`RXGL_DOWN_MSB:`RXGL_DOWN_LSB];
  assign init_gain = thr_ff[`RXGL_INIT_MSB:`RXGL_INIT_LSB];

  // ************************************************
  // Magnitude averager
  // ************************************************
  localparam int ACC_W = MAG_W + 4;
  logic [ACC_W-1:0] acc_ff, nxt_acc, acc_sum;
  logic [3:0] cnt_ff, nxt_cnt, last_cnt;
  logic [MAG_W-1:0] avg_ff, nxt_avg;
  logic avg_vld_ff, nxt_avg_vld;
  logic rx_on_ff, nxt_rx_on;
  logic rx_rise;

  assign rx_rise = rx_on && !rx_on_ff;
  // Last sample index of a window of 2 << code samples
  assign last_cnt = 4'((4'h2 << magnitude_avg_len) - 4'h1);
  assign acc_sum = acc_ff + ACC_W'(sample_mag);

  always_comb begin
    nxt_acc = acc_ff;
    nxt_cnt = cnt_ff;
    nxt_avg = avg_ff;
    nxt_avg_vld = 1'b0;
    nxt_rx_on = rx_on;
    if (!rx_on || rx_rise) begin
      // Start every receive period with a fresh window
      nxt_acc = '0;
      nxt_cnt = 4'h0;
    end else if (sample_valid) begin
      if (cnt_ff >= last_cnt) begin
        // Shift amount kept in three bits, else code 3 wraps to no division
        nxt_avg = MAG_W'(acc_sum >> (3'(magnitude_avg_len) + 3'h1));
        nxt_avg_vld = 1'b1;
        nxt_acc = '0;
        nxt_cnt = 4'h0;
      end else begin
        nxt_acc = acc_sum;
        nxt_cnt = cnt_ff + 4'h1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      acc_ff <= '0;
      cnt_ff <= 4'h0;
      avg_ff <= '0;
      avg_vld_ff <= 1'b0;
      rx_on_ff <= 1'b0;
    end else begin
      acc_ff <= nxt_acc;
      cnt_ff <= nxt_cnt;
      avg_ff <= nxt_avg;
      avg_vld_ff <= nxt_avg_vld;
      rx_on_ff <= nxt_rx_on;
    end
  end

  assign avg_mag = avg_ff;
  assign avg_valid = avg_vld_ff;

  // ************************************************
  // Gain loop
  // ************************************************
  logic [6:0] up_thr, dn_thr;
  logic want_up, want_dn;
  logic [4:0] gain_ff, nxt_gain;
  rxgl_hyst_t hyst_ff, nxt_hyst;

  assign up_thr = 7'(sense_level) + 7'(up_margin);
  assign dn_thr = up_thr + `RXGL_DOWN_BASE + 7'(down_code);
  assign want_up = (avg_ff < MAG_W'(up_thr)) && (gain_ff < init_gain);
  assign want_dn = (avg_ff > MAG_W'(dn_thr)) && (gain_ff != 5'h00);

  always_comb begin
    nxt_gain = gain_ff;
    nxt_hyst = hyst_ff;
    if (rx_rise || gain_loop_off) begin
      nxt_gain = init_gain;
      nxt_hyst = RXGL_HOLD;
    end else if (avg_vld_ff) begin
      if (gain_ff > init_gain) begin
        // Ceiling lowered by software: jump to it at the next evaluation
        nxt_gain = init_gain;
        nxt_hyst = RXGL_HOLD;
      end else if (want_up) begin
        if (!gain_step_hyst || hyst_ff == RXGL_PEND_UP) begin
          nxt_gain = gain_ff + 5'h01;
          nxt_hyst = RXGL_HOLD;
        end else begin
          nxt_hyst = RXGL_PEND_UP;
        end
      end else if (want_dn) begin
        if (!gain_step_hyst || hyst_ff == RXGL_PEND_DN) begin
          nxt_gain = gain_ff - 5'h01;
          nxt_hyst = RXGL_HOLD;
        end else begin
          nxt_hyst = RXGL_PEND_DN;
        end
      end else begin
        nxt_hyst = RXGL_HOLD;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      gain_ff <= 5'h00;
      hyst_ff <= RXGL_HOLD;
    end else begin
      gain_ff <= nxt_gain;
      hyst_ff <= nxt_hyst;
    end
  end

  assign vga_gain = gain_ff;

  // ************************************************
  // Second amplifier stage
  // ************************************************
  rxgl_amp_t amp_ff, nxt_amp;
  rxgl_amp_t amp_floor, amp_ceil;
  logic [5:0] swp_code;

  assign amp_floor = floor_sel ? RXGL_AMP_MED : RXGL_AMP_MIN;
  assign amp_ceil = ceil_sel ? RXGL_AMP_MAX : RXGL_AMP_MED;

  always_comb begin
    unique case (switch_point)
      2'h0: swp_code = `RXGL_SWP_CODE0;
      2'h1: swp_code = `RXGL_SWP_CODE1;
      2'h2: swp_code = `RXGL_SWP_CODE2;
      2'h3: swp_code = `RXGL_SWP_CODE3;
    endcase
    if (floor_sel && !ceil_sel) begin
      unique case (switch_point)
        2'h0: nxt_amp = RXGL_AMP_MID_HIGH;
        2'h1: nxt_amp = RXGL_AMP_MIN;
        2'h2: nxt_amp = RXGL_AMP_MED;
        2'h3: nxt_amp = RXGL_AMP_MAX;
      endcase
    end else begin
      // High amplifier codes mean weak signal: second stage at its ceiling
      nxt_amp = (6'(gain_ff) >= swp_code) ? amp_ceil : amp_floor;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      amp_ff <= RXGL_AMP_MIN;
    end else begin
      amp_ff <= nxt_amp;
    end
  end

  assign second_amp_stage = amp_ff;

  // ************************************************
  // Assertions
  // ************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  AST_OFF_HOLDS: assert property (gain_loop_off |=> gain_ff == $past(init_gain))
    else $error("gain not held at initial code while loop off");
  AST_RX_LOAD: assert property (rx_rise |=> gain_ff == $past(init_gain))
    else $error("initial gain not loaded at receive start");
  AST_CEILING: assert property ((gain_ff > $past(gain_ff)) |-> gain_ff <= $past(init_gain))
    else $error("gain raised above ceiling");
  AST_ONE_STEP: assert property (avg_vld_ff && !rx_rise && !gain_loop_off && gain_ff <= init_gain
      |=> (gain_ff == $past(gain_ff)) || (gain_ff == $past(gain_ff) + 5'h01)
        || (gain_ff == $past(gain_ff) - 5'h01))
    else $error("gain moved more than one step");
  AST_NO_EVAL_STILL: assert property (!avg_vld_ff && !rx_rise && !gain_loop_off
      |=> gain_ff == $past(gain_ff))
    else $error("gain changed without an evaluation");
  AST_DOWN_STEP: assert property (avg_vld_ff && !rx_rise && !gain_loop_off && !gain_step_hyst
      && gain_ff <= init_gain && !want_up && want_dn |=> gain_ff == $past(gain_ff) - 5'h01)
    else $error("gain not lowered above down threshold");
  AST_UP_STEP: assert property (avg_vld_ff && !rx_rise && !gain_loop_off && !gain_step_hyst
      && want_up |=> gain_ff == $past(gain_ff) + 5'h01)
    else $error("gain not raised below up threshold");
  AST_HYST_WAIT: assert property (avg_vld_ff && !rx_rise && !gain_loop_off && gain_step_hyst
      && hyst_ff == RXGL_HOLD && gain_ff <= init_gain |=> gain_ff == $past(gain_ff))
    else $error("single step taken without two evaluations");
  AST_FIXED_STAGE: assert property (floor_sel && !ceil_sel && switch_point == 2'h1
      |=> amp_ff == RXGL_AMP_MIN)
    else $error("fixed second stage gain wrong");
  // Settings must stay put across the edge that registers the stage
  AST_STAGE_BOUNDS: assert property (!(floor_sel && !ceil_sel) ##1 $stable(ctrl_ff)
      |-> amp_ff == amp_floor || amp_ff == amp_ceil)
    else $error("second stage outside floor and ceiling");
  AST_FIXED_HIGH: assert property (floor_sel && !ceil_sel && switch_point == 2'h0
      |=> amp_ff == RXGL_AMP_MID_HIGH)
    else $error("fixed second stage not between medium and maximum");
  AST_FIXED_MED: assert property (floor_sel && !ceil_sel && switch_point == 2'h2
      |=> amp_ff == RXGL_AMP_MED)
    else $error("fixed second stage not medium");
  AST_AVG_SPACING: assert property (avg_vld_ff |=> !avg_vld_ff)
    else $error("averages closer than two samples");

  COV_UP: cover property (avg_vld_ff && want_up ##1 gain_ff == $past(gain_ff) + 5'h01);
  COV_DOWN: cover property (avg_vld_ff && want_dn ##1 gain_ff == $past(gain_ff) - 5'h01);
  COV_PEND: cover property (hyst_ff == RXGL_PEND_UP ##[1:64] gain_ff > $past(gain_ff));
  COV_RX_LOAD: cover property (rx_rise);

endmodule

`default_nettype wire

//--- verification/rxgl_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****************
// Host side of the configuration port
// ****************
module rxgl_host_model (
  input wire logic clk, // Bench clock
  output var logic [6:0] cfg_addr, // Register offset
  output var logic cfg_wr_en, // Write strobe
  output var logic cfg_rd_en, // Read strobe
  output var logic [7:0] cfg_wdata, // Write data
  input wire logic [7:0] cfg_rdata // Read data
);
  initial begin
    cfg_addr = 7'h00;
    cfg_wr_en = 1'b0;
    cfg_rd_en = 1'b0;
    cfg_wdata = 8'h00;
  end
  // Data inverted once the strobe drops, so a stale value never looks valid
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge clk);
    cfg_addr <= a;
    cfg_wdata <= d;
    cfg_wr_en <= 1'b1;
    @(posedge clk);
    cfg_wr_en <= 1'b0;
    cfg_wdata <= ~d;
  endtask
  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    @(posedge clk);
    cfg_addr <= a;
    cfg_rd_en <= 1'b1;
    @(posedge clk);
    cfg_rd_en <= 1'b0;
    #1;
    d = cfg_rdata;
  endtask
endmodule
`default_nettype wire

//--- verification/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "rxgl_regs.svh"
module tb_top;
  import rxgl_pkg::*;
  localparam logic [6:0] CTL = `RXGL_GAIN_STAGE_CONTROL_OFS;
  localparam logic [6:0] THR = `RXGL_GAIN_THRESHOLD_START_OFS;
  logic clk, rst_n, rx_on, sample_valid, avg_valid, cfg_wr_en, cfg_rd_en;
  logic [6:0] cfg_addr;
  logic [7:0] cfg_wdata, cfg_rdata, sample_mag, avg_mag, last_avg, rd;
  logic [4:0] sense_level, vga_gain;
  logic [2:0] up_margin;
  rxgl_amp_t second_amp_stage;
  int fails, comparisons, npulse;
  rxgl_core #(.MAG_W(8)) uut (.clk(clk), .rst_n(rst_n), .cfg_addr(cfg_addr), .cfg_wr_en(cfg_wr_en),
    .cfg_rd_en(cfg_rd_en), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .rx_on(rx_on),
    .sample_valid(sample_valid), .sample_mag(sample_mag), .sense_level(sense_level), .up_margin(up_margin),
    .vga_gain(vga_gain), .second_amp_stage(second_amp_stage), .avg_mag(avg_mag), .avg_valid(avg_valid));
  rxgl_host_model host (.clk(clk), .cfg_addr(cfg_addr), .cfg_wr_en(cfg_wr_en), .cfg_rd_en(cfg_rd_en),
    .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    if (avg_valid === 1'b1) begin
      npulse++;
      last_avg = avg_mag;
    end
  end
  // ****************
  // Helpers
  // ****************
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      fails++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask
  // Toggling the chain restarts the averaging window, so each test starts aligned
  task automatic rx_cycle();
    @(posedge clk);
    rx_on <= 1'b0;
    repeat (2) @(posedge clk);
    rx_on <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    npulse = 0;
  endtask
  task automatic feed(input logic [7:0] m, input int n);
    for (int k = 0; k < n; k++) begin
      @(posedge clk);
      sample_valid <= 1'b1;
      sample_mag <= m + 8'(k);
    end
    @(posedge clk);
    sample_valid <= 1'b0;
    sample_mag <= ~m;
    repeat (4) @(posedge clk);
    #1;
  endtask
  // Two samples m and m+1 average to m after truncation
  task automatic step(input logic [7:0] m, input logic [4:0] g);
    feed(m, 2);
    chk("vga_gain", {3'h0, g}, {3'h0, vga_gain});
  endtask
  function automatic logic [1:0] exp_stage(input logic [3:0] b, input logic [4:0] g);
    logic [5:0] sw;
    sw = (b[1:0] == 2'h0) ? 6'h00 : (b[1:0] == 2'h1) ? 6'h0a : (b[1:0] == 2'h2) ? 6'h13 : 6'h20;
    if (b[3:2] == 2'b10) return (b[1:0] == 2'h0) ? 2'h3 : b[1:0] - 2'h1;
    if ({1'b0, g} >= sw) return b[2] ? 2'h2 : 2'h1;
    return b[3] ? 2'h1 : 2'h0;
  endfunction
  task automatic print_verdict();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // ****************
  // Scenarios
  // ****************
  task automatic t_regs();
    host.rd(CTL, rd);
    chk("ctl_reset", 8'h75, rd);
    host.rd(THR, rd);
    chk("thr_reset", 8'h38, rd);
    host.rd(7'h14, rd);
    chk("unmapped", 8'h00, rd);
    host.wr(THR, 8'hc7);
    host.rd(THR, rd);
    chk("thr_rw", 8'hc7, rd);
    $display("test regs done");
  endtask
  task automatic t_avg();
    for (int c = 0; c < 4; c++) begin
      host.wr(CTL, {6'b011100, 2'(c)});
      rx_cycle();
      feed(8'h28, 2 << c);
      chk("avg_count", 8'h01, npulse[7:0]);
      chk("avg_mag", 8'h28 + 8'((1 << c) - 1), last_avg);
    end
    $display("test avg done");
  endtask
  task automatic t_gain();
    host.wr(THR, 8'h38);
    host.wr(CTL, 8'h50);
    rx_cycle();
    chk("vga_gain", 8'h18, {3'h0, vga_gain});
    step(8'h10, 5'h18);
    step(8'h11, 5'h17);
    step(8'h1e, 5'h16);
    step(8'h0c, 5'h16);
    step(8'h0b, 5'h17);
    step(8'h00, 5'h18);
    step(8'h00, 5'h18);
    host.wr(THR, 8'hf8);
    step(8'h16, 5'h18);
    step(8'h17, 5'h17);
    @(posedge clk);
    sense_level <= 5'h0e;
    up_margin <= 3'h0;
    step(8'h0d, 5'h18);
    step(8'h19, 5'h17);
    $display("test gain done");
  endtask
  task automatic t_hyst();
    host.wr(CTL, 8'h54);
    step(8'h1e, 5'h17);
    step(8'h1e, 5'h16);
    step(8'h10, 5'h16);
    step(8'h1e, 5'h16);
    step(8'h10, 5'h16);
    step(8'h00, 5'h16);
    step(8'h00, 5'h17);
    $display("test hyst done");
  endtask
  task automatic t_off();
    host.wr(THR, 8'h25);
    rx_cycle();
    chk("vga_gain", 8'h05, {3'h0, vga_gain});
    host.wr(CTL, 8'h48);
    step(8'h1e, 5'h05);
    $display("test off done");
  endtask
  task automatic t_stage();
    logic [4:0] g;
    logic [3:0] b;
    for (int i = 0; i < 48; i++) begin
      g = (i % 3 == 0) ? 5'h09 : (i % 3 == 1) ? 5'h0a : 5'h13;
      b = 4'(i / 3);
      host.wr(THR, {3'h1, g});
      host.wr(CTL, {b, 4'h8});
      repeat (4) @(posedge clk);
      #1;
      chk("second_amp_stage", {6'h0, exp_stage(b, g)}, {6'h0, second_amp_stage});
    end
    $display("test stage done");
  endtask
  initial begin
    rst_n = 1'b0;
    rx_on = 1'b0;
    sample_valid = 1'b0;
    sample_mag = 8'h00;
    sense_level = 5'h0a;
    up_margin = 3'h2;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    t_regs();
    t_avg();
    t_gain();
    t_hyst();
    t_off();
    t_stage();
    print_verdict();
  end
  // Whole run needs under 2000 cycles
  initial begin
    repeat (5000) @(posedge clk);
    fails++;
    print_verdict();
  end
endmodule
`default_nettype wire
